/* logic/nbcrt_core.sv */
// Register and control core of a 4-bit controller: transfers, branches,
// calls, returns, ROM table read, skips and the port D pull-down control.
// Assumes a synchronous ROM: data for rom_addr is valid one clock later.
`timescale 1ns/1ps
//Contract
// [RULE1] Taken skip nullifies next instruction; each nullified word takes one cycle.
// [RULE2] Skipped table read, return or return-with-skip takes exactly one cycle.
// [RULE3] Pull-down bits drive pins 7..4; one enables pull-down and wakeup.
// [RULE4] Program counter is 11 bits: 4-bit page and 7-bit in-page field.
// [RULE5] RAM pointer is 2-bit file index joined to 4-bit word index.
// [RULE6] Four 11-bit return entries, 2-bit index; call pushes, return pops.
// [RULE7] Transfer register loads from B and accumulator and unloads back.
// [RULE8] Table read pushes, reads page p word into B and accumulator, pops.
// [RULE9] With top-bit flag set, table read also copies bit 8 into carry.
// [RULE10] One-cycle copies B, accumulator, word index, carry untouched.
// [RULE11] Pull-down register written only from accumulator by its instruction.
module nbcrt_core
	import nbcrt_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            arst_n,
	output logic      [PC_W-1:0] rom_addr,
	input  wire logic [8:0]      rom_data,
	output logic      [5:0]      ram_pointer,
	output logic      [3:0]      port_d_pulldown,
	output logic      [3:0]      acc,
	output logic      [3:0]      breg,
	output logic                 carry_flag,
	output logic                 instr_done
);

	nbcrt_state_t    st_q, st_d;
	logic [PC_W-1:0] pc_q, pc_d, rom_addr_q, rom_addr_d, pc_inc, stk_rd;
	logic [3:0]      acc_q, acc_d, b_q, b_d, y_q, y_d, pd_q, pd_d;
	logic [3:0]      page_hold_q, page_hold_d, cnt_q, cnt_d;
	logic [1:0]      x_q, x_d, sp_q, sp_d;
	logic [7:0]      xfer_q, xfer_d;
	logic [2:0]      toff_q, toff_d;
	logic            carry_q, carry_d, topbit_q, topbit_d;
	logic            skip_q, skip_d, word2_q, word2_d, done_q, done_d;
	logic            stk_we;
	logic [1:0]      stk_wa;
	logic [PC_W-1:0] stk_wd;
	logic            is_rom_table_read, is_ret, exec_live;

	assign pc_inc    = pc_q + 11'h001;
	assign is_rom_table_read   = rom_data[8:4] == OPP_TABLE;
	assign is_ret    = rom_data == OP_RET || rom_data == OP_RETSKIP;
	assign exec_live = st_q == ST_EXEC && !skip_q;

	nbcrt_stack_mem u_stack (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.wr_en    (stk_we),
		.wr_addr  (stk_wa),
		.wr_data  (stk_wd),
		.rd_addr  (sp_d),
		.rd_data  (stk_rd)
	);

	always_comb
	begin
		st_d        = st_q;
		pc_d        = pc_q;
		rom_addr_d  = rom_addr_q;
		acc_d       = acc_q;
		b_d         = b_q;
		y_d         = y_q;
		x_d         = x_q;
		pd_d        = pd_q;
		sp_d        = sp_q;
		xfer_d      = xfer_q;
		toff_d      = toff_q;
		carry_d     = carry_q;
		topbit_d    = topbit_q;
		skip_d      = skip_q;
		word2_d     = word2_q;
		page_hold_d = page_hold_q;
		cnt_d       = cnt_q;
		done_d      = 1'b0;
		stk_we      = 1'b0;
		stk_wa      = sp_q + 2'h1;
		stk_wd      = pc_inc;
		unique case (st_q)
			ST_FETCH:
				st_d = ST_EXEC;
			ST_EXEC:
			begin
				pc_d       = pc_inc;
				rom_addr_d = pc_inc;
				st_d       = ST_FETCH;
				done_d     = 1'b1;
				skip_d     = 1'b0;
				word2_d    = 1'b0;
				if (skip_q) // [RULE2]
				begin
					// Nullified word; a two-word branch keeps its second word dead
					if (!word2_q && (rom_data[8:4] == OPP_BRL ||
						rom_data[8:4] == OPP_CALLL))
					begin
						skip_d  = 1'b1; // [RULE1]
						word2_d = 1'b1;
					end
				end
				else if (word2_q)
				begin
					pc_d = {page_hold_q, rom_data[6:0]}; // [RULE4]
					rom_addr_d = {page_hold_q, rom_data[6:0]};
					if (rom_data[8:7] == OPP_CALL)
					begin
						stk_we = 1'b1; // [RULE6]
						sp_d   = sp_q + 2'h1;
					end
				end
				else if (rom_data[8:7] == OPP_BRANCH)
				begin
					pc_d       = {pc_q[PC_W-1:PAGE_LSB], rom_data[6:0]}; // [RULE4]
					rom_addr_d = {pc_q[PC_W-1:PAGE_LSB], rom_data[6:0]};
				end
				else if (rom_data[8:7] == OPP_CALL)
				begin
					stk_we     = 1'b1; // [RULE6]
					sp_d       = sp_q + 2'h1;
					pc_d       = {PAGE_CALL_SHORT, rom_data[6:0]};
					rom_addr_d = {PAGE_CALL_SHORT, rom_data[6:0]};
				end
				else if (rom_data[8:4] == OPP_BRL || rom_data[8:4] == OPP_CALLL)
				begin
					word2_d     = 1'b1;
					page_hold_d = rom_data[3:0];
				end
				else if (is_rom_table_read)
				begin
					// Own pc is kept; the stack entry is written for fidelity
					stk_we     = 1'b1; // [RULE8]
					sp_d       = sp_q + 2'h1;
					rom_addr_d = {rom_data[3:0], toff_q, acc_q};
					st_d       = ST_TWAIT;
					done_d     = 1'b0;
				end
				else if (is_ret)
				begin
					pc_d       = stk_rd; // [RULE6]
					rom_addr_d = stk_rd;
					sp_d       = sp_q - 2'h1;
					skip_d     = rom_data == OP_RETSKIP;
					cnt_d      = RET_STALL;
					st_d       = ST_STALL;
					done_d     = 1'b0;
				end
				else if (rom_data[8:4] == OPP_LOADA)
					acc_d = rom_data[3:0];
				else if (rom_data[8:6] == OPP_LOADXY)
				begin
					x_d = rom_data[5:4]; // [RULE5]
					y_d = rom_data[3:0];
				end
				else
				begin
					case (rom_data)
						OP_TAB:     acc_d    = b_q; // [RULE10]
						OP_TBA:     b_d      = acc_q; // [RULE10]
						OP_TAY:     acc_d    = y_q; // [RULE10]
						OP_TYA:     y_d      = acc_q; // [RULE10]
						OP_LOAD_TRANSFER_REG:    xfer_d   = {b_q, acc_q}; // [RULE7]
						OP_UNLOAD_TRANSFER_REG:    {b_d, acc_d} = xfer_q; // [RULE7]
						OP_TDA:     toff_d   = acc_q[2:0];
						OP_TOPBIT:  topbit_d = 1'b1;
						OP_PDWRITE: pd_d     = acc_q; // [RULE11]
						OP_SETC:    carry_d  = 1'b1;
						OP_CLRC:    carry_d  = 1'b0;
						OP_SKIPNC:  skip_d   = !carry_q; // [RULE1]
						default:    pd_d     = pd_q;
					endcase
				end
			end
			ST_TWAIT:
				st_d = ST_TDATA;
			ST_TDATA:
			begin
				b_d   = rom_data[7:4]; // [RULE8]
				acc_d = rom_data[3:0];
				if (topbit_q)
					carry_d = rom_data[8]; // [RULE9]
				sp_d       = sp_q - 2'h1; // [RULE8]
				rom_addr_d = pc_q;
				cnt_d      = TBL_STALL;
				st_d       = ST_STALL;
			end
			ST_STALL:
			begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q <= 4'h1)
				begin
					st_d   = ST_FETCH;
					done_d = 1'b1;
				end
			end
			default:
				st_d = ST_FETCH;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q        <= ST_FETCH;
			pc_q        <= PC_RST;
			rom_addr_q  <= PC_RST;
			acc_q       <= ACC_RST;
			b_q         <= NIB_RST;
			y_q         <= NIB_RST;
			x_q         <= 2'h0;
			pd_q        <= PD_RST;
			sp_q        <= SP_RST;
			xfer_q      <= XFER_RST;
			toff_q      <= TOFF_RST;
			carry_q     <= 1'b0;
			topbit_q    <= 1'b0;
			skip_q      <= 1'b0;
			word2_q     <= 1'b0;
			page_hold_q <= NIB_RST;
			cnt_q       <= 4'h0;
			done_q      <= 1'b0;
		end
		else
		begin
			st_q        <= st_d;
			pc_q        <= pc_d;
			rom_addr_q  <= rom_addr_d;
			acc_q       <= acc_d;
			b_q         <= b_d;
			y_q         <= y_d;
			x_q         <= x_d;
			pd_q        <= pd_d;
			sp_q        <= sp_d;
			xfer_q      <= xfer_d;
			toff_q      <= toff_d;
			carry_q     <= carry_d;
			topbit_q    <= topbit_d;
			skip_q      <= skip_d;
			word2_q     <= word2_d;
			page_hold_q <= page_hold_d;
			cnt_q       <= cnt_d;
			done_q      <= done_d;
		end
	end

	assign rom_addr        = rom_addr_q;
	assign ram_pointer     = {x_q, y_q}; // [RULE5]
	assign port_d_pulldown = pd_q; // [RULE3]
	assign acc             = acc_q;
	assign breg            = b_q;
	assign carry_flag      = carry_q;
	assign instr_done      = done_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_rom_table_read_start;
		exec_live && !word2_q && is_rom_table_read;
	endsequence
	sequence s_rom_table_read_body;
		st_q == ST_TWAIT ##1 st_q == ST_TDATA ##1 st_q == ST_STALL;
	endsequence

	chk_skip_nullify: assert property ( // [RULE1]
		st_q == ST_EXEC && skip_q |=> $stable(acc_q) && $stable(b_q)
			&& $stable(carry_q) && $stable(pd_q))
		else $error("skipped instruction changed state");
	chk_skip_short: assert property ( // [RULE2]
		st_q == ST_EXEC && skip_q && !word2_q && (is_rom_table_read || is_ret)
			|=> st_q == ST_FETCH && done_q)
		else $error("skipped table or return not one cycle");
	chk_pulldown_write: assert property ( // [RULE3]
		exec_live && !word2_q && rom_data == OP_PDWRITE
			|=> port_d_pulldown == $past(acc_q))
		else $error("pull-down register not loaded from accumulator");
	chk_pulldown_hold: assert property ( // [RULE11]
		!(exec_live && !word2_q && rom_data == OP_PDWRITE)
			|=> $stable(port_d_pulldown))
		else $error("pull-down register changed without its write");
	chk_page_branch: assert property ( // [RULE4]
		exec_live && !word2_q && rom_data[8:7] == OPP_BRANCH
			|=> pc_q == {$past(pc_q[PC_W-1:PAGE_LSB]), $past(rom_data[6:0])})
		else $error("in-page branch wrong");
	chk_ram_pointer: assert property ( // [RULE5]
		exec_live && !word2_q && rom_data[8:6] == OPP_LOADXY
			|=> ram_pointer == $past(rom_data[5:0]))
		else $error("ram pointer not formed from indexes");
	chk_call_push: assert property ( // [RULE6]
		exec_live && !word2_q && rom_data[8:7] == OPP_CALL
			|=> sp_q == $past(sp_q) + 2'h1 && stk_rd == $past(pc_q) + 11'h001)
		else $error("call did not push its return address");
	chk_return_pop: assert property ( // [RULE6]
		exec_live && !word2_q && is_ret
			|=> pc_q == $past(stk_rd) && sp_q == $past(sp_q) - 2'h1)
		else $error("return did not pop the saved address");
	chk_xfer_load: assert property ( // [RULE7]
		exec_live && !word2_q && rom_data == OP_LOAD_TRANSFER_REG
			|=> xfer_q == {$past(b_q), $past(acc_q)})
		else $error("transfer register load wrong");
	chk_table_seq: assert property ( // [RULE8]
		s_rom_table_read_start |=> s_rom_table_read_body ##0 (acc_q == $past(rom_data[3:0])
			&& b_q == $past(rom_data[7:4]) && sp_q == $past(sp_q, 3)))
		else $error("table read sequence wrong");
	chk_table_len: assert property ( // [RULE8]
		s_rom_table_read_start |=> !done_q [*4] ##1 done_q)
		else $error("table read length wrong");
	chk_top_bit: assert property ( // [RULE9]
		st_q == ST_TDATA |=> carry_q == ($past(topbit_q) ? $past(rom_data[8])
			: $past(carry_q)))
		else $error("carry not governed by top-bit flag");
	chk_reg_copy: assert property ( // [RULE10]
		exec_live && !word2_q && rom_data == OP_TAB
			|=> acc_q == $past(b_q) && $stable(carry_q) && done_q)
		else $error("register copy wrong");

endmodule : nbcrt_core

/* logic/nbcrt_stack_mem.sv */
// Four-entry return-address store with a registered read port.
// Assumes one writer; a write to the entry being read is forwarded.
`timescale 1ns/1ps
module nbcrt_stack_mem
	import nbcrt_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            arst_n,
	input  wire logic            wr_en,
	input  wire logic [1:0]      wr_addr,
	input  wire logic [PC_W-1:0] wr_data,
	input  wire logic [1:0]      rd_addr,
	output logic      [PC_W-1:0] rd_data
);

	logic [PC_W-1:0] mem_q [4];
	logic [PC_W-1:0] rd_q;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_entry
			always_ff @(posedge core_clk)
			begin
				if (wr_en && wr_addr == 2'(gi))
					mem_q[gi] <= wr_data;
			end
		end
	endgenerate

	// Forwarding keeps a return right after a call from seeing stale data
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_q <= PC_RST;
		else if (wr_en && wr_addr == rd_addr)
			rd_q <= wr_data;
		else
			rd_q <= mem_q[rd_addr];
	end

	assign rd_data = rd_q;

endmodule : nbcrt_stack_mem

/* pkg/nbcrt_pkg.sv */
// Shared constants for the nibble controller register-transfer core.
// Assumes a synchronous program ROM with one clock of read latency.
package nbcrt_pkg;

	// One machine cycle takes this many core clocks (fetch wait + execute)
	localparam int CLK_PER_CYC = 2;
	// Machine cycles of the multi-cycle instructions
	localparam int TBL_CYCLES  = 3;
	localparam int RET_CYCLES  = 2;
	// Extra clocks spent in the stall state after the fixed steps
	localparam logic [3:0] TBL_STALL = 4'(CLK_PER_CYC * TBL_CYCLES - 4);
	localparam logic [3:0] RET_STALL = 4'(CLK_PER_CYC * RET_CYCLES - 2);

	// Field positions of the program counter
	localparam int PC_W       = 11;
	localparam int PAGE_LSB   = 7;
	localparam logic [3:0] PAGE_CALL_SHORT = 4'h2;

	// Reset values
	localparam logic [3:0]  ACC_RST   = 4'hf;
	localparam logic [3:0]  NIB_RST   = 4'h0;
	localparam logic [1:0]  SP_RST    = 2'h3;
	localparam logic [10:0] PC_RST    = 11'h000;
	localparam logic [3:0]  PD_RST    = 4'h0;
	localparam logic [7:0]  XFER_RST  = 8'h00;
	localparam logic [2:0]  TOFF_RST  = 3'h0;

	// Opcode prefixes (instruction word bits 8..4 or 8..7 or 8..6)
	localparam logic [1:0] OPP_BRANCH   = 2'h3;
	localparam logic [1:0] OPP_CALL     = 2'h2;
	localparam logic [4:0] OPP_BRL      = 5'h03;
	localparam logic [4:0] OPP_CALLL    = 5'h07;
	localparam logic [4:0] OPP_TABLE    = 5'h0a;
	localparam logic [4:0] OPP_LOADA    = 5'h0b;
	localparam logic [2:0] OPP_LOADXY   = 3'h3;

	// Single-word fixed opcodes
	localparam logic [8:0] OP_NOP       = 9'h000;
	localparam logic [8:0] OP_TAB       = 9'h040;
	localparam logic [8:0] OP_TBA       = 9'h041;
	localparam logic [8:0] OP_TAY       = 9'h042;
	localparam logic [8:0] OP_TYA       = 9'h043;
	localparam logic [8:0] OP_LOAD_TRANSFER_REG      = 9'h044;
	localparam logic [8:0] OP_UNLOAD_TRANSFER_REG      = 9'h045;
	localparam logic [8:0] OP_TDA       = 9'h046;
	localparam logic [8:0] OP_RET       = 9'h047;
	localparam logic [8:0] OP_RETSKIP   = 9'h048;
	localparam logic [8:0] OP_TOPBIT    = 9'h049;
	localparam logic [8:0] OP_PDWRITE   = 9'h04a;
	localparam logic [8:0] OP_SETC      = 9'h04b;
	localparam logic [8:0] OP_CLRC      = 9'h04c;
	localparam logic [8:0] OP_SKIPNC    = 9'h04d;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_EXEC  = 3'b001,
		ST_TWAIT = 3'b010,
		ST_TDATA = 3'b011,
		ST_STALL = 3'b100
	} nbcrt_state_t;

endpackage : nbcrt_pkg

/* verif/nbcrt_core_tb.sv */
// Self-checking bench for the register-transfer core.
// Assumes the ROM model answers every fetch; inputs move on falling edges.
`timescale 1ns/1ps
module nbcrt_core_tb;
	import nbcrt_pkg::*;
	logic            core_clk;
	logic            arst_n;
	logic [PC_W-1:0] rom_addr;
	logic [8:0]      rom_data;
	logic [5:0]      ram_pointer;
	logic [3:0]      port_d_pulldown;
	logic [3:0]      acc;
	logic [3:0]      breg;
	logic            carry_flag;
	logic            instr_done;
	int              errors;
	int              tests_run;
	int              cyc;
	int              last_done;

	nbcrt_core dut_u (
		.core_clk        (core_clk),
		.arst_n          (arst_n),
		.rom_addr        (rom_addr),
		.rom_data        (rom_data),
		.ram_pointer     (ram_pointer),
		.port_d_pulldown (port_d_pulldown),
		.acc             (acc),
		.breg            (breg),
		.carry_flag      (carry_flag),
		.instr_done      (instr_done)
	);

	nbcrt_rom_model rom_u (
		.core_clk (core_clk),
		.rom_addr (rom_addr),
		.rom_data (rom_data)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Each scenario needs well under a hundred clocks
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			results();
		end
	end

	task results;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	// Whole ROM is cleared first so stray fetches run as no-ops
	task rst(input logic [8:0] w[$]);
		arst_n = 1'b0;
		foreach (rom_u.mem[i])
			rom_u.mem[i] = OP_NOP;
		foreach (w[i])
			rom_u.mem[i] = w[i];
		repeat (6) @(negedge core_clk);
		chk({4'h0, acc, breg, port_d_pulldown}, 16'h0f00);
		chk(16'(rom_addr), 16'h0000);
		arst_n = 1'b1;
		last_done = cyc;
	endtask : rst

	// Gap of zero skips the timing check
	task step(input int gap);
		int n;
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (instr_done !== 1'b1 && n < 40);
		chk(16'(instr_done), 16'h0001);
		if (gap > 0)
			chk(16'(cyc - last_done), 16'(gap));
		last_done = cyc;
	endtask : step

	task steps(input int k);
		repeat (k) step(2);
	endtask : steps

	task t_transfers;
		rst('{OP_SETC, 9'h0b5, OP_TBA, 9'h0b9, 9'h0e7, OP_TAY, 9'h0b3,
			OP_TYA, OP_LOAD_TRANSFER_REG, 9'h0b0, OP_TBA, OP_UNLOAD_TRANSFER_REG});
		step(0);
		steps(2);
		chk(16'(breg), 16'h0005);
		steps(2);
		chk(16'(ram_pointer), 16'h0027);
		steps(1);
		chk(16'(acc), 16'h0007);
		steps(2);
		chk(16'(ram_pointer), 16'h0023);
		steps(3);
		chk(16'({breg, acc}), 16'h0000);
		steps(1);
		chk(16'({breg, acc}), 16'h0053);
		chk(16'(carry_flag), 16'h0001);
	endtask : t_transfers

	task t_table;
		rst('{9'h0b3, OP_TDA, 9'h0b4, 9'h0a5, OP_TOPBIT, OP_CLRC, 9'h0b4,
			9'h0a5});
		rom_u.mem[11'h2b4] = 9'h1a7;
		step(0);
		steps(2);
		step(6);
		chk(16'({breg, acc}), 16'h00a7);
		chk(16'(carry_flag), 16'h0000);
		chk(16'(rom_addr), 16'h0004);
		steps(3);
		step(6);
		chk(16'({carry_flag, breg, acc}), 16'h01a7);
	endtask : t_table

	task t_skips;
		rst('{OP_CLRC, OP_SKIPNC, 9'h0a5, OP_SKIPNC, 9'h0b1, OP_SETC,
			OP_SKIPNC, 9'h0b2, OP_TAB, OP_CLRC, OP_SKIPNC, OP_RET, 9'h0b6});
		step(0);
		steps(1);
		step(2);
		chk(16'(acc), 16'h000f);
		steps(2);
		chk(16'(acc), 16'h000f);
		steps(3);
		chk(16'(acc), 16'h0002);
		steps(1);
		chk(16'(acc), 16'h0000);
		steps(2);
		step(2);
		chk(16'(rom_addr), 16'h000c);
		steps(1);
		chk(16'(acc), 16'h0006);
	endtask : t_skips

	task t_calls;
		rst('{9'h075, 9'h10a, 9'h0b7, 9'h0b9, 9'h03a, 9'h17f});
		rom_u.mem[11'h28a] = OP_RETSKIP;
		rom_u.mem[11'h57f] = OP_PDWRITE;
		rom_u.mem[11'h580] = 9'h07b;
		rom_u.mem[11'h581] = 9'h105;
		rom_u.mem[11'h585] = OP_RET;
		step(0);
		steps(1);
		chk(16'(rom_addr), 16'h028a);
		step(4);
		chk(16'(rom_addr), 16'h0002);
		steps(1);
		chk(16'(acc), 16'h000f);
		steps(3);
		chk(16'({port_d_pulldown, rom_addr}), 16'h057f);
		steps(1);
		chk(16'(port_d_pulldown), 16'h0009);
		chk(16'(rom_addr), 16'h0580);
		steps(2);
		chk(16'(rom_addr), 16'h0585);
		step(4);
		chk(16'(rom_addr), 16'h0582);
	endtask : t_calls

	// In-page branch, short call, long branch, return, nullified long branch
	task t_branches;
		rst('{9'h0b3, 9'h1c5});
		rom_u.mem[11'h045] = 9'h104;
		rom_u.mem[11'h046] = 9'h0b8;
		rom_u.mem[11'h047] = OP_SKIPNC;
		rom_u.mem[11'h048] = 9'h033;
		rom_u.mem[11'h049] = 9'h1ff;
		rom_u.mem[11'h04a] = 9'h0b2;
		rom_u.mem[11'h0a0] = OP_RET;
		rom_u.mem[11'h104] = 9'h031;
		rom_u.mem[11'h105] = 9'h1a0;
		step(0);
		steps(1);
		chk(16'(rom_addr), 16'h0045);
		steps(1);
		chk(16'(rom_addr), 16'h0104);
		steps(2);
		chk(16'(rom_addr), 16'h00a0);
		step(4);
		chk(16'(rom_addr), 16'h0046);
		steps(4);
		chk(16'(acc), 16'h0008);
		chk(16'(rom_addr), 16'h004a);
		steps(1);
		chk(16'(acc), 16'h0002);
	endtask : t_branches

	initial
	begin
		errors = 0;
		tests_run = 0;
		cyc = 0;
		last_done = 0;
		arst_n = 1'b0;
		t_transfers();
		t_table();
		t_skips();
		t_calls();
		t_branches();
		results();
	end
endmodule : nbcrt_core_tb

/* verif/nbcrt_rom_model.sv */
// Behavioural program ROM facing the core's fetch port.
// Assumes the bench preloads mem before the core fetches from it.
`timescale 1ns/1ps
module nbcrt_rom_model
(
	input  wire logic        core_clk,
	input  wire logic [10:0] rom_addr,
	output logic      [8:0]  rom_data
);
	logic [8:0] mem [2048];

	// Registered read: a new address shows its word one clock later
	always_ff @(posedge core_clk)
	begin
		rom_data <= mem[rom_addr];
	end
endmodule : nbcrt_rom_model
